// [logic/line_diag_consts.vh]
// constants for the line diagnosis unit
// assumes an 8-bit register port with a 2-bit word address
`ifndef LINE_DIAG_CONSTS_VH
`define LINE_DIAG_CONSTS_VH
// register addresses
`define ADDR_CTRL 2'h0
`define ADDR_STATUS 2'h1
`define ADDR_CMD 2'h2
// control register fields and reset value
`define CTRL_RESET 8'h00
`define CTRL_DIV_HI 7
`define CTRL_DIV_LO 4
`define CTRL_MODE_HI 3
`define CTRL_MODE_LO 2
`define CTRL_TIP_EN 1
`define CTRL_SDC_EN 0
// command register: manual diagnosis clock pulse
`define CMD_MANUAL_SDC 0
// diagnosis states, also the status encoding
`define ST_NOMINAL 2'h0
`define ST_DEG_COMP 2'h1
`define ST_DEG_TRUE 2'h2
`define ST_MAJOR 2'h3
// selection modes
`define MODE_DIFF 2'h0
`define MODE_COMP 2'h1
`define MODE_TRUE 2'h2
`define MODE_AUTO 2'h3
// timing counts
`define SAMPLES_PER_TS 4'hf
`define FILTER_SAMPLES 3'h5
`define EDGE_LIMIT 3'h4
`define TX_CHECK_SAMPLES 3'h6
`define DOMINANT_TS_LIMIT 4'h8
`define SDC_BASE 22'h00_0040
`endif

// [logic/line_diag.v]
// line fault diagnosis and receive-input selection for a two-wire bus
// assumes i_sample_tick pulses 16 times per timeslot on i_clk, and the
// frame logic on i_clk gives one-cycle pulses for eof and tx start/end
`timescale 1ns/100ps
`include "line_diag_consts.vh"
module line_diag (
    // clock and reset
    input wire i_clk,
    input wire i_arst_n,
    // register port
    input wire [1:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    // line receivers, asynchronous pins
    input wire i_diff_receiver_in,
    input wire i_true_wire_receiver_in,
    input wire i_comp_wire_receiver_in,
    // frame logic, same clock
    input wire i_sample_tick,
    input wire i_eof_detect,
    input wire i_tx_start,
    input wire i_tx_end,
    input wire i_ack_only,
    input wire i_tx_data,
    // outputs
    output reg o_rx_data,
    output wire o_diag_state_hi,
    output wire o_diag_state_lo,
    output wire o_input_mismatch_flag,
    output reg o_return_to_idle_pulse,
    output reg o_diag_sync_clock,
    output reg o_tx_in_progress
);

    reg [7:0] ctrl_q;
    reg manual_sdc_q;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg mismatch_q;
    reg alt_q;
    reg [3:0] sample_cnt_q;
    reg [21:0] div_cnt_q;
    reg [2:0] cnt_true_q;
    reg [2:0] cnt_comp_q;
    reg [2:0] cnt_sel_q;
    reg [2:0] tx_dom_cnt_q;
    reg [3:0] dom_ts_q;
    reg fail_seen_q;
    reg clean_q;
    wire [2:0] pin_in;
    wire [2:0] filt;
    wire [2:0] edge_p;
    wire [1:0] mode;
    wire ts_tick;
    wire [21:0] div_limit;
    wire div_tick;
    wire sdc_tick;
    wire ri;
    reg sel_level;
    reg sel_edge;
    reg fail_true;
    reg fail_comp;
    reg fail_major;

    assign pin_in = {i_comp_wire_receiver_in, i_true_wire_receiver_in,
                     i_diff_receiver_in};
    assign mode = {ctrl_q[`CTRL_MODE_HI], ctrl_q[`CTRL_MODE_LO]};
    assign o_diag_state_hi = state_q[1];
    assign o_diag_state_lo = state_q[0];
    assign o_input_mismatch_flag = mismatch_q;

    // per-input synchroniser and five-sample filter
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : rx_chan
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg stable_q;
            reg level_q;
            reg edge_q;
            reg [2:0] run_q;
            always @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    s1_q <= 1'b1;
                    s2_q <= 1'b1;
                    s3_q <= 1'b1;
                    stable_q <= 1'b1;
                    level_q <= 1'b1;
                    edge_q <= 1'b0;
                    run_q <= 3'h0;
                end else begin
                    s1_q <= pin_in[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        stable_q <= s3_q;
                    end
                    edge_q <= 1'b0;
                    if (i_sample_tick) begin
                        if (stable_q == level_q) begin
                            run_q <= 3'h0;
                        end else if (run_q == `FILTER_SAMPLES - 3'h1) begin
                            level_q <= stable_q;
                            edge_q <= 1'b1;
                            run_q <= 3'h0;
                        end else begin
                            run_q <= run_q + 3'h1;
                        end
                    end
                end
            end
            assign filt[g] = level_q;
            assign edge_p[g] = edge_q;
        end
    endgenerate

    // timeslot tick and diagnosis clock divider
    assign ts_tick = i_sample_tick && (sample_cnt_q == `SAMPLES_PER_TS);
    assign div_limit = (`SDC_BASE << ctrl_q[`CTRL_DIV_HI:`CTRL_DIV_LO]) - 22'h00_0001;
    assign div_tick = ctrl_q[`CTRL_SDC_EN] && ts_tick && (div_cnt_q == div_limit);
    // divider period is never below 64 timeslots; manual pulses from the command register can come at any spacing
    assign sdc_tick = div_tick || manual_sdc_q;
    // return to idle suppressed in automatic mode
    assign ri = i_eof_detect && (mode != `MODE_AUTO);

    // reception input selection
    always @* begin
        sel_level = filt[0];
        sel_edge = edge_p[0];
        if (mode == `MODE_AUTO) begin
            if (state_q == `ST_DEG_COMP) begin
                sel_level = filt[2];
                sel_edge = edge_p[2];
            end else if (state_q == `ST_DEG_TRUE) begin
                sel_level = filt[1];
                sel_edge = edge_p[1];
            end else if (state_q == `ST_MAJOR) begin
                sel_level = alt_q ? filt[2] : filt[1];
                sel_edge = alt_q ? edge_p[2] : edge_p[1];
            end
        end else if (mode == `MODE_COMP) begin
            sel_level = filt[2];
            sel_edge = edge_p[2];
        end else if (mode == `MODE_TRUE) begin
            sel_level = filt[1];
            sel_edge = edge_p[1];
        end
    end

    // fault detection from filtered signals only
    always @* begin
        fail_true = 1'b0;
        fail_comp = 1'b0;
        fail_major = 1'b0;
        if (cnt_true_q == `EDGE_LIMIT && cnt_comp_q == 3'h0) begin
            fail_comp = 1'b1;
        end
        if (cnt_comp_q == `EDGE_LIMIT && cnt_true_q == 3'h0) begin
            fail_true = 1'b1;
        end
        if (o_tx_in_progress && !i_tx_data && tx_dom_cnt_q == `TX_CHECK_SAMPLES &&
            filt[1] != filt[2]) begin
            // the wire still reading recessive is the faulty one
            fail_true = fail_true | filt[1];
            fail_comp = fail_comp | filt[2];
        end
        if (sdc_tick && cnt_sel_q < `EDGE_LIMIT) begin
            fail_major = 1'b1;
        end
        if (ts_tick && !sel_level && dom_ts_q == `DOMINANT_TS_LIMIT - 4'h1) begin
            fail_major = 1'b1;
        end
    end

    // diagnosis state transitions
    always @* begin
        state_d = state_q;
        if (sdc_tick && mode != `MODE_AUTO) begin
            state_d = `ST_NOMINAL;
        end
        if (ri) begin
            state_d = `ST_NOMINAL;
        end
        if (sdc_tick && mode == `MODE_AUTO && clean_q && !fail_seen_q) begin
            state_d = `ST_NOMINAL;
        end
        if (fail_true) begin
            state_d = (state_d == `ST_DEG_TRUE) ? `ST_MAJOR : `ST_DEG_COMP;
        end
        if (fail_comp) begin
            state_d = (state_d == `ST_DEG_COMP || fail_true) ?
                      `ST_MAJOR : `ST_DEG_TRUE;
        end
        if (fail_major) begin
            state_d = `ST_MAJOR;
        end
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= `ST_NOMINAL;
            mismatch_q <= 1'b0;
            sample_cnt_q <= 4'h0;
            o_rx_data <= 1'b1;
            o_return_to_idle_pulse <= 1'b0;
            o_diag_sync_clock <= 1'b0;
        end else begin
            state_q <= state_d;
            o_rx_data <= sel_level;
            o_return_to_idle_pulse <= ri;
            o_diag_sync_clock <= sdc_tick;
            // set wins over clear
            if (!(filt[0] == filt[1] && filt[1] == filt[2])) begin
                mismatch_q <= 1'b1;
            end else if (ri) begin
                mismatch_q <= 1'b0;
            end
            if (i_sample_tick) begin
                sample_cnt_q <= sample_cnt_q + 4'h1;
            end
        end
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            div_cnt_q <= 22'h00_0000;
        end else begin
            if (!ctrl_q[`CTRL_SDC_EN] || div_tick) begin
                div_cnt_q <= 22'h00_0000;
            end else if (ts_tick) begin
                div_cnt_q <= div_cnt_q + 22'h00_0001;
            end
        end
    end

    // edge counts per wire; an interval ends once both wires move
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_true_q <= 3'h0;
            cnt_comp_q <= 3'h0;
            cnt_sel_q <= 3'h0;
        end else begin
            if (sdc_tick || (cnt_true_q != 3'h0 && cnt_comp_q != 3'h0) ||
                fail_true || fail_comp) begin
                cnt_true_q <= 3'h0;
                cnt_comp_q <= 3'h0;
            end else begin
                if (edge_p[1] && cnt_true_q != `EDGE_LIMIT) begin
                    cnt_true_q <= cnt_true_q + 3'h1;
                end
                if (edge_p[2] && cnt_comp_q != `EDGE_LIMIT) begin
                    cnt_comp_q <= cnt_comp_q + 3'h1;
                end
            end
            if (sdc_tick) begin
                cnt_sel_q <= 3'h0;
            end else if (sel_edge && cnt_sel_q != `EDGE_LIMIT) begin
                cnt_sel_q <= cnt_sel_q + 3'h1;
            end
        end
    end

    // dominant drive must outlast the filter before comparing
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tx_dom_cnt_q <= 3'h0;
            dom_ts_q <= 4'h0;
        end else begin
            if (!o_tx_in_progress || i_tx_data) begin
                tx_dom_cnt_q <= 3'h0;
            end else if (i_sample_tick && tx_dom_cnt_q != `TX_CHECK_SAMPLES) begin
                tx_dom_cnt_q <= tx_dom_cnt_q + 3'h1;
            end
            if (ts_tick) begin
                if (sel_level || fail_major) begin
                    dom_ts_q <= 4'h0;
                end else begin
                    dom_ts_q <= dom_ts_q + 4'h1;
                end
            end
        end
    end

    // two clean diagnosis edges needed before going nominal in automatic mode
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fail_seen_q <= 1'b0;
            clean_q <= 1'b0;
        end else begin
            if (sdc_tick) begin
                clean_q <= !fail_seen_q && !fail_true && !fail_comp && !fail_major;
                fail_seen_q <= 1'b0;
            end else if (fail_true || fail_comp || fail_major) begin
                fail_seen_q <= 1'b1;
            end
        end
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            alt_q <= 1'b0;
        end else begin
            if (state_q != `ST_MAJOR) begin
                alt_q <= 1'b0;
            end else if (sdc_tick) begin
                alt_q <= !alt_q;
            end
        end
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_tx_in_progress <= 1'b0;
        end else begin
            if (!ctrl_q[`CTRL_TIP_EN] || i_tx_end) begin
                o_tx_in_progress <= 1'b0;
            end else if (i_tx_start && !i_ack_only) begin
                o_tx_in_progress <= 1'b1;
            end
        end
    end

    // register port
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_q <= `CTRL_RESET;
            manual_sdc_q <= 1'b0;
            o_rdata <= 8'h00;
        end else begin
            manual_sdc_q <= i_wr && (i_addr == `ADDR_CMD) && i_wdata[`CMD_MANUAL_SDC];
            if (i_wr && i_addr == `ADDR_CTRL) begin
                ctrl_q <= i_wdata;
            end
            o_rdata <= 8'h00;
            if (i_rd) begin
                if (i_addr == `ADDR_CTRL) begin
                    o_rdata <= ctrl_q;
                end else if (i_addr == `ADDR_STATUS) begin
                    o_rdata <= {5'h00, state_q, mismatch_q};
                end
            end
        end
    end

endmodule

// [dv/line_diag_checker.sv]
// port assertions for the line diagnosis unit
// assumes one clock; selection mode is tracked from control writes
`timescale 1ns/100ps
`include "line_diag_consts.vh"
module line_diag_checker (
    // clock, reset and register port
    input wire i_clk,
    input wire i_arst_n,
    input wire [1:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    // frame strobes
    input wire i_eof_detect,
    input wire i_tx_start,
    input wire i_tx_end,
    input wire i_ack_only,
    // diagnosis outputs
    input wire o_diag_state_hi,
    input wire o_diag_state_lo,
    input wire o_input_mismatch_flag,
    input wire o_return_to_idle_pulse,
    input wire o_diag_sync_clock,
    input wire o_tx_in_progress
);
    reg [7:0] ctrl_q;
    wire auto_w = ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO] == `MODE_AUTO;
    wire [1:0] st_w = {o_diag_state_hi, o_diag_state_lo};
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n)
            ctrl_q <= `CTRL_RESET;
        else if (i_wr && i_addr == `ADDR_CTRL)
            ctrl_q <= i_wdata;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    a_ri_after_eof: assert property (i_eof_detect && !auto_w |=> o_return_to_idle_pulse)
        else $error("no idle pulse after end of frame");
    a_ri_only_eof: assert property (o_return_to_idle_pulse |-> $past(i_eof_detect) && !$past(auto_w))
        else $error("idle pulse without cause");
    a_ri_to_nominal: assert property (o_return_to_idle_pulse |-> ##[0:2] st_w == `ST_NOMINAL)
        else $error("idle pulse left state off nominal");
    a_flag_clear: assert property ($fell(o_input_mismatch_flag) |->
        o_return_to_idle_pulse || $past(o_return_to_idle_pulse))
        else $error("mismatch flag cleared without idle pulse");
    a_status_read: assert property (i_rd && i_addr == `ADDR_STATUS |=> o_rdata == {5'h00,
        $past(o_diag_state_hi), $past(o_diag_state_lo), $past(o_input_mismatch_flag)})
        else $error("status read differs from status outputs");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    a_tip_start: assert property (i_tx_start && ctrl_q[`CTRL_TIP_EN] && !i_ack_only && !i_tx_end
        |=> o_tx_in_progress)
        else $error("transmission flag missing after start");
    a_tip_ack_only: assert property (!o_tx_in_progress && i_ack_only |=> !o_tx_in_progress)
        else $error("transmission flag for acknowledge only");
    a_tip_end: assert property (i_tx_end |=> !o_tx_in_progress)
        else $error("transmission flag stayed after end");
    a_tip_cause: assert property ($rose(o_tx_in_progress) |->
        $past(i_tx_start) && $past(ctrl_q[`CTRL_TIP_EN]))
        else $error("transmission flag rose without enabled start");
    a_manual_sdc: assert property (i_wr && i_addr == `ADDR_CMD && i_wdata[`CMD_MANUAL_SDC]
        |-> ##2 o_diag_sync_clock)
        else $error("manual diagnosis clock pulse missing");
    c_ri: cover property (o_return_to_idle_pulse);
    c_tip: cover property ($rose(o_tx_in_progress));
    c_major: cover property (st_w == `ST_MAJOR);
endmodule
bind line_diag line_diag_checker u_chk (.i_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_eof_detect, .i_tx_start, .i_tx_end, .i_ack_only, .o_diag_state_hi,
    .o_diag_state_lo, .o_input_mismatch_flag, .o_return_to_idle_pulse, .o_diag_sync_clock,
    .o_tx_in_progress);

// [dv/line_partner.sv]
// behavioural bus wires with three line receivers
// assumes low is dominant; an open wire floats to its recessive pull level
`timescale 1ns/100ps
module line_partner (
    // other nodes and the device transmitter
    input wire i_drive,
    input wire i_tx_data,
    // open-wire faults
    input wire i_fault_true,
    input wire i_fault_comp,
    // receiver outputs
    output wire o_diff,
    output wire o_true,
    output wire o_comp
);
    wire bus_w = i_drive & i_tx_data;
    assign o_true = bus_w | i_fault_true;
    assign o_comp = bus_w | i_fault_comp;
    // differential still reads while one wire is alive
    assign o_diff = bus_w | (i_fault_true & i_fault_comp);
endmodule

// [dv/tb.sv]
// self-checking bench for the line diagnosis unit
// assumes the partner model drives the three receiver pins
`timescale 1ns/100ps
`include "line_diag_consts.vh"
`define CHK(n, e, g) begin checks = checks + 1; if ((g) !== (e)) begin \
    fail_count = fail_count + 1; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
    reg i_clk = 1'b0;
    reg i_arst_n = 1'b0;
    reg [1:0] i_addr = 2'h0;
    reg [7:0] i_wdata = 8'h00;
    reg i_wr = 1'b0;
    reg i_rd = 1'b0;
    reg i_sample_tick = 1'b0;
    reg i_eof_detect = 1'b0;
    reg i_tx_start = 1'b0;
    reg i_tx_end = 1'b0;
    reg i_ack_only = 1'b0;
    reg i_tx_data = 1'b1;
    reg drive = 1'b1;
    reg fault_true = 1'b0;
    reg fault_comp = 1'b0;
    reg [1:0] tick_cnt = 2'h0;
    reg [7:0] st;
    reg seen;
    wire [7:0] o_rdata;
    wire i_diff_receiver_in, i_true_wire_receiver_in, i_comp_wire_receiver_in, o_rx_data;
    wire o_diag_state_hi, o_diag_state_lo, o_input_mismatch_flag, o_return_to_idle_pulse;
    wire o_diag_sync_clock, o_tx_in_progress;
    integer fail_count = 0;
    integer checks = 0;
    line_diag uut (.i_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_diff_receiver_in, .i_true_wire_receiver_in, .i_comp_wire_receiver_in,
        .i_sample_tick, .i_eof_detect, .i_tx_start, .i_tx_end, .i_ack_only, .i_tx_data,
        .o_rx_data, .o_diag_state_hi, .o_diag_state_lo, .o_input_mismatch_flag,
        .o_return_to_idle_pulse, .o_diag_sync_clock, .o_tx_in_progress);
    line_partner far (.i_drive(drive), .i_tx_data, .i_fault_true(fault_true),
        .i_fault_comp(fault_comp), .o_diff(i_diff_receiver_in),
        .o_true(i_true_wire_receiver_in), .o_comp(i_comp_wire_receiver_in));
    initial forever #20 i_clk = ~i_clk;
    // 16 sample ticks per 64-cycle timeslot
    always @(posedge i_clk) begin
        tick_cnt <= tick_cnt + 2'h1;
        i_sample_tick <= &tick_cnt;
    end
    task wr(input [1:0] a, input [7:0] d);
        begin
            @(posedge i_clk);
            {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
            @(posedge i_clk);
            i_wr <= 1'b0;
        end
    endtask
    task rd(input [1:0] a, output [7:0] d);
        begin
            @(posedge i_clk);
            {i_rd, i_addr} <= {1'b1, a};
            @(posedge i_clk);
            i_rd <= 1'b0;
            @(negedge i_clk);
            d = o_rdata;
        end
    endtask
    // k is {eof, tx start, tx end}; returns the idle pulse seen next cycle
    task pulse(input [2:0] k);
        begin
            @(posedge i_clk);
            {i_eof_detect, i_tx_start, i_tx_end} <= k;
            @(posedge i_clk);
            {i_eof_detect, i_tx_start, i_tx_end} <= 3'h0;
            @(negedge i_clk);
            seen = o_return_to_idle_pulse;
        end
    endtask
    // ten samples a level; the period drifts against the timeslot grid,
    // so no long run of dominant timeslot samples builds up
    task toggle(input integer n);
        repeat (n) begin
            @(posedge i_clk);
            drive <= ~drive;
            repeat (39) @(posedge i_clk);
        end
    endtask
    task t_reset;
        begin
            rd(`ADDR_CTRL, st);
            `CHK("ctrl reset", `CTRL_RESET, st)
            rd(`ADDR_STATUS, st);
            `CHK("status reset", 8'h00, st)
            rd(2'h3, st);
            `CHK("unmapped read", 8'h00, st)
        end
    endtask
    task t_degrade;
        begin
            wr(`ADDR_CTRL, 8'h0c);
            fault_comp <= 1'b1;
            toggle(6);
            rd(`ADDR_STATUS, st);
            `CHK("degraded status", 8'h05, st)
            pulse(3'h4);
            `CHK("idle pulse auto", 1'b0, seen)
            rd(`ADDR_STATUS, st);
            `CHK("flag kept", 8'h05, st)
            fault_comp <= 1'b0;
            wr(`ADDR_CTRL, 8'h00);
            pulse(3'h4);
            `CHK("idle pulse forced", 1'b1, seen)
            rd(`ADDR_STATUS, st);
            `CHK("status after idle", 8'h00, st)
        end
    endtask
    task t_major;
        begin
            wr(`ADDR_CTRL, 8'h0c);
            repeat (3) wr(`ADDR_CMD, 8'h01);
            rd(`ADDR_STATUS, st);
            `CHK("silent major", `ST_MAJOR, st[2:1])
            repeat (3) begin
                toggle(6);
                wr(`ADDR_CMD, 8'h01);
            end
            rd(`ADDR_STATUS, st);
            `CHK("auto recovery", `ST_NOMINAL, st[2:1])
            @(posedge i_clk);
            drive <= 1'b0;
            repeat (576) @(posedge i_clk);
            drive <= 1'b1;
            rd(`ADDR_STATUS, st);
            `CHK("dominant major", `ST_MAJOR, st[2:1])
        end
    endtask
    task t_tip;
        begin
            wr(`ADDR_CTRL, 8'h02);
            pulse(3'h4);
            pulse(3'h2);
            `CHK("tip start", 1'b1, o_tx_in_progress)
            pulse(3'h1);
            `CHK("tip end", 1'b0, o_tx_in_progress)
            i_ack_only <= 1'b1;
            pulse(3'h2);
            `CHK("tip ack only", 1'b0, o_tx_in_progress)
            i_ack_only <= 1'b0;
            pulse(3'h2);
            fault_comp <= 1'b1;
            i_tx_data <= 1'b0;
            repeat (64) @(posedge i_clk);
            i_tx_data <= 1'b1;
            pulse(3'h1);
            rd(`ADDR_STATUS, st);
            `CHK("tx diagnosis", `ST_DEG_TRUE, st[2:1])
            fault_comp <= 1'b0;
            wr(`ADDR_CTRL, 8'h00);
            pulse(3'h2);
            `CHK("tip disabled", 1'b0, o_tx_in_progress)
        end
    endtask
    // forced single-wire modes, then differential mode, with the complement wire open
    task t_select;
        begin
            wr(`ADDR_CTRL, 8'h04);
            fault_comp <= 1'b1;
            drive <= 1'b0;
            repeat (40) @(posedge i_clk);
            `CHK("rx comp wire", 1'b1, o_rx_data)
            wr(`ADDR_CTRL, 8'h08);
            repeat (2) @(negedge i_clk);
            `CHK("rx true wire", 1'b0, o_rx_data)
            wr(`ADDR_CTRL, 8'h00);
            repeat (2) @(negedge i_clk);
            `CHK("rx diff", 1'b0, o_rx_data)
            drive <= 1'b1;
            fault_comp <= 1'b0;
        end
    endtask
    // divider 0 keeps the period short for the run
    task t_divider;
        integer n;
        begin
            wr(`ADDR_CTRL, 8'h01);
            n = 0;
            do begin
                @(negedge i_clk);
                n = n + 1;
            end while (o_diag_sync_clock !== 1'b1 && n < 5000);
            if (n >= 5000) begin
                fail_count = fail_count + 1;
                summarize;
            end
            n = 0;
            do begin
                @(negedge i_clk);
                n = n + 1;
            end while (o_diag_sync_clock !== 1'b1 && n < 5000);
            if (n >= 5000) begin
                fail_count = fail_count + 1;
                summarize;
            end
            `CHK("sdc period", 4096, n)
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", checks, fail_count);
            if (fail_count == 0 && checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (16) @(posedge i_clk);
        i_arst_n <= 1'b1;
        t_reset;
        t_degrade;
        t_major;
        t_tip;
        t_select;
        t_divider;
        summarize;
    end
endmodule
